// >>> hw/dsw_consts.vh
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH
// Frame layout
`define DSW_FRAME_BITS 24
`define DSW_CNT_W 5
`define DSW_DATA_BITS 16
`define DSW_DATA_LSB 0
`define DSW_DATA_MSB 15
`define DSW_PM_LO_POS 16
`define DSW_PM_HI_POS 17
// Reset values
`define DSW_MIDSCALE 16'h8000
`define DSW_PM_NORMAL 2'h0
// Host timing limits, not referenced by the design or the bench
`define DSW_SCLK_MAX_MHZ 30
`define DSW_CS_HIGH_MIN_NS 12
`endif

// >>> hw/dsw_sync2.v
`timescale 1ns/1ns
// Two-stage synchroniser for a group of pin inputs
module dsw_sync2 #(
  parameter WIDTH = 3
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire [WIDTH-1:0] i_async,
  input wire [WIDTH-1:0] i_idle,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage; both rest at the pins' idle levels in reset
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_q <= i_idle;
      o_sync <= i_idle;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // dsw_sync2

// >>> hw/dsw_serial_port.v
// Overview of operation
// - A 24-bit input shift register receives each write frame.
// - Data bit is shifted in on each serial clock falling edge.
// - Active-low frame select enables shifting while it is low.
// - After the 24th falling edge the word is applied to the converter.
// - Frame select rising before the 24th edge aborts the partial write.
// - Frame holds six unused bits, two power-mode bits, then sixteen converter data bits.
// - Abort clears the shift register, keeps data and mode unchanged.
// - Reset loads midscale and holds it until a complete frame arrives.
`timescale 1ns/1ns
`include "dsw_consts.vh"
module dsw_serial_port #(
  parameter FRAME_BITS = `DSW_FRAME_BITS,
  parameter DATA_BITS = `DSW_DATA_BITS
) (
  input wire i_clk,
  input wire i_rst_b,
  // Host pins
  input wire i_sync_b,
  input wire i_sclk,
  input wire i_din,
  // Converter register and power mode
  output reg [DATA_BITS-1:0] o_dac_code,
  output reg o_power_mode_bit_hi,
  output reg o_power_mode_bit_lo,
  // One-cycle outcome strobes
  output reg o_update,
  output reg o_abort
);
  // Frame states, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // Power mode restored by reset, one bit per pin
  localparam [1:0] PM_RESET = `DSW_PM_NORMAL;

  // Resting levels of frame select, serial clock and data, in synchroniser order
  localparam [2:0] PIN_IDLE = 3'h7;

  // Synchronised pin levels
  wire [2:0] pins_s;
  wire sync_b_s;
  wire sclk_s;
  wire din_s;
  // Edge history and frame state
  reg sync_b_q;
  reg sclk_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [FRAME_BITS-1:0] shift_q;
  reg [FRAME_BITS-1:0] shift_d;
  // Count of falling edges seen in this frame
  reg [`DSW_CNT_W-1:0] cnt_q;
  reg [`DSW_CNT_W-1:0] cnt_d;
  // Next values of the outputs
  reg [DATA_BITS-1:0] code_d;
  reg pm_hi_d;
  reg pm_lo_d;
  reg update_d;
  reg abort_d;
  // Edge strobes
  wire sclk_fall;
  wire sync_fall;
  wire sync_rise;
  wire last_edge;
  // Shift network output and the fields of the word
  wire [FRAME_BITS-1:0] shift_in;
  wire [DATA_BITS-1:0] word_code;
  wire word_pm_hi;
  wire word_pm_lo;

  // Pins are outside our clock domain; the synchroniser rests at the idle levels in reset
  // Each serial clock phase must span more than one system clock to be seen
  dsw_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_sync_b, i_sclk, i_din}),
    .i_idle(PIN_IDLE),
    .o_sync(pins_s)
  );

  // Split the synchronised group back into its pins
  assign sync_b_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  // Serial clock falls carry the data, taken from the same synchroniser sample
  assign sclk_fall = sclk_q & ~sclk_s;
  // Frame select edges open and abort frames
  assign sync_fall = sync_b_q & ~sync_b_s;
  assign sync_rise = ~sync_b_q & sync_b_s;

  // Shift network, one stage per bit: bit 0 takes the data pin, the rest their lower neighbour
  genvar gi;
  generate
    for (gi = 0; gi < FRAME_BITS; gi = gi + 1) begin : g_shift
      if (gi == 0) begin : g_head
        assign shift_in[gi] = din_s;
      end else begin : g_body
        assign shift_in[gi] = shift_q[gi-1];
      end
    end
  endgenerate

  // Fields of the word as it stands after the closing edge; the top six bits carry nothing
  assign word_code = shift_in[`DSW_DATA_MSB:`DSW_DATA_LSB];
  assign word_pm_hi = shift_in[`DSW_PM_HI_POS];
  assign word_pm_lo = shift_in[`DSW_PM_LO_POS];

  // Closing edge: the one that arrives with the count at frame length less one
  assign last_edge = (cnt_q == FRAME_BITS - 1);

  // Frame control: counts falling edges while selected, aborts on an early rise
  always @* begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    update_d = 1'b0;
    abort_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // A fresh falling edge of frame select opens the frame
        if (sync_fall) begin
          cnt_d = {`DSW_CNT_W{1'b0}};
          shift_d = {FRAME_BITS{1'b0}};
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // An early rise wins over a clock edge seen in the same sample
        if (sync_rise) begin
          shift_d = {FRAME_BITS{1'b0}};
          cnt_d = {`DSW_CNT_W{1'b0}};
          abort_d = 1'b1;
          state_d = ST_IDLE;
        end else if (sclk_fall) begin
          shift_d = shift_in;
          cnt_d = cnt_q + 1'b1;
          // The closing edge commits the word and ends the frame
          if (last_edge) begin
            update_d = 1'b1;
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // Further clocks ignored until frame select goes high
        if (sync_b_s) begin
          cnt_d = {`DSW_CNT_W{1'b0}};
          state_d = ST_IDLE;
        end
      end
      default: begin
        // Illegal state code: fall back to idle
        state_d = ST_IDLE;
      end
    endcase
  end

  // Converter register and mode move only on a completed frame; an abort leaves both alone
  always @* begin
    code_d = o_dac_code;
    pm_hi_d = o_power_mode_bit_hi;
    pm_lo_d = o_power_mode_bit_lo;
    if (update_d) begin
      code_d = word_code;
      pm_hi_d = word_pm_hi;
      pm_lo_d = word_pm_lo;
    end
  end

  // Edge history, reset to the idle levels so that no false edge follows reset
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync_b_q <= PIN_IDLE[2];
      sclk_q <= PIN_IDLE[1];
    end else begin
      sync_b_q <= sync_b_s;
      sclk_q <= sclk_s;
    end
  end

  // Frame state, shifter and edge count
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      shift_q <= {FRAME_BITS{1'b0}};
      cnt_q <= {`DSW_CNT_W{1'b0}};
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
    end
  end

  // Converter register and power mode: midscale and normal mode after reset
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_dac_code <= `DSW_MIDSCALE;
      o_power_mode_bit_hi <= PM_RESET[1];
      o_power_mode_bit_lo <= PM_RESET[0];
    end else begin
      o_dac_code <= code_d;
      o_power_mode_bit_hi <= pm_hi_d;
      o_power_mode_bit_lo <= pm_lo_d;
    end
  end

  // Outcome pulses, one cycle each
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_update <= 1'b0;
      o_abort <= 1'b0;
    end else begin
      o_update <= update_d;
      o_abort <= abort_d;
    end
  end
endmodule // dsw_serial_port

// >>> verification/dsw_host.sv
`timescale 1ns/1ns
module dsw_host(
  output logic o_sync_b = 1'b1,
  output logic o_sclk = 1'b1,
  output logic o_din = 1'b0
);
  // Sends n bits MSB first; the clock rests high outside frames
  task send(input [23:0] w, input int n);
    o_sync_b = 0;
    #400;
    for (int i = 23; i > 23 - n; i--) begin
      o_din = w[i];
      #400 o_sclk = 0;
      #400 o_sclk = 1;
    end
    #800 o_din = ~o_din;
    o_sync_b = 1;
    #1000;
  endtask
endmodule // dsw_host

// >>> verification/dsw_chk.sv
`timescale 1ns/1ns
module dsw_chk(
  input wire i_clk,
  input wire i_rst_b,
  input wire i_sync_b,
  input wire [15:0] o_dac_code,
  input wire o_power_mode_bit_hi,
  input wire o_power_mode_bit_lo,
  input wire o_update,
  input wire o_abort
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Outcome pulses, their causes and what may move the outputs
  a_upd_pulse: assert property (o_update |=> !o_update) else $error("update long");
  a_abt_pulse: assert property (o_abort |=> !o_abort) else $error("abort long");
  a_not_both: assert property (!(o_update && o_abort)) else $error("both");
  a_code_hold: assert property ($changed(o_dac_code) |-> o_update) else $error("code moved");
  a_mode_hold: assert property ($changed({o_power_mode_bit_hi, o_power_mode_bit_lo}) |-> o_update)
    else $error("mode moved");
  // Pin to strobe latency is three samples: two synchroniser stages and the output register
  a_upd_sel: assert property (o_update |-> !$past(i_sync_b, 3)) else $error("unselected");
  a_abt_rise: assert property (o_abort |-> $past(i_sync_b, 3)) else $error("selected");
  a_rst_mid: assert property (disable iff (1'b0) !i_rst_b |=> o_dac_code == 16'h8000)
    else $error("no midscale");
endmodule // dsw_chk
bind dsw_serial_port dsw_chk u_chk(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sync_b(i_sync_b),
  .o_dac_code(o_dac_code), .o_power_mode_bit_hi(o_power_mode_bit_hi), .o_power_mode_bit_lo(o_power_mode_bit_lo),
  .o_update(o_update), .o_abort(o_abort));

// >>> verification/dsw_serial_port_tb.sv
`timescale 1ns/1ns
module dsw_serial_port_tb;
  logic i_clk = 0;
  logic i_rst_b = 0;
  wire sb, sc, di, hi, lo, up, ab;
  wire [15:0] code;
  int miscompares = 0, num_checks = 0, ue = 0, ae = 0, n;
  logic [8:0] nu = 0, na = 0;
  logic [31:0] s = 32'h8DF3;
  logic [23:0] w;
  logic [17:0] ex = 18'h08000;
  always #50 i_clk = ~i_clk;
  // Outcome pulse counters; four-state so an unknown strobe shows in the compare
  always @(posedge i_clk) begin
    if (i_rst_b) begin
      nu <= nu + up;
      na <= na + ab;
    end
  end
  dsw_host u_dsw_host(.o_sync_b(sb), .o_sclk(sc), .o_din(di));
  dsw_serial_port u_dsw_serial_port(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sync_b(sb), .i_sclk(sc), .i_din(di),
    .o_dac_code(code), .o_power_mode_bit_hi(hi), .o_power_mode_bit_lo(lo), .o_update(up), .o_abort(ab));
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function logic [17:0] exp_of(input logic [23:0] f);
    return f[17:0];
  endfunction
  task chk(input string m, input [17:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", m, e, g);
    end
  endtask
  // Holds reset for c cycles, then checks midscale and lets the synchronisers settle
  task do_reset(input int c);
    i_rst_b = 0;
    repeat (c) @(posedge i_clk);
    #5 i_rst_b = 1;
    ex = 18'h08000;
    chk("reset", ex, {hi, lo, code});
    repeat (3) @(posedge i_clk);
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Full frames in every mode, aborts at 0, 23 and random bits, a mid-run reset, then recovery
  initial begin
    do_reset(20);
    for (int t = 0; t < 10; t++) begin
      if (t == 5) @(posedge i_clk) #5 do_reset(3);
      s = xs(s);
      w = {s[23:18], t[1:0], s[15:0]};
      n = t == 4 ? 0 : t == 6 ? 23 : t == 7 ? 1 + s[20:16] % 22 : 24;
      @(posedge i_clk) #5 u_dsw_host.send(w, n);
      if (n == 24) ex = exp_of(w);
      ue += n == 24;
      ae += n < 24;
      chk("word", ex, {hi, lo, code});
      chk("pulses", {9'(ue), 9'(ae)}, {nu, na});
      $display("test %0d done", t);
    end
    print_verdict;
  end
  // Ten frames of about 22 us each plus resets; allow close to twice that
  initial begin
    #(10 * 40000);
    miscompares++;
    print_verdict;
  end
endmodule // dsw_serial_port_tb
